//--- tpr_core.sv
`timescale 1ns/1ps
`default_nettype none
module tpr_core
(
  input  wire logic                      mclk_i,
  input  wire logic                      sys_rst_i,
  input  wire logic                      vdd_good_i,
  input  wire logic                      vbus_good_i,
  input  wire logic                      soft_reset_bit_i,
  output logic                           soft_reset_bit_o,
  input  wire logic                      look_for_connection_cmd_i,
  input  wire logic [tpr_pkg::IRQ_W-1:0] irq_clr_i,
  input  wire logic [tpr_pkg::IRQ_W-1:0] irq_mask_i,
  output logic [tpr_pkg::IRQ_W-1:0]      irq_stat_o,
  input  wire logic                      addr_select_pin_i,
  input  wire logic                      serial_pair_swap_i,
  output logic [6:0]                     slave_addr_o,
  input  wire logic                      gp_out_val_i,
  output logic                           addr_select_gp_out_o,
  output logic                           addr_select_gp_out_oe_o,
  output logic [tpr_pkg::FUSE_AW-1:0]    fuse_addr_o,
  input  wire logic [7:0]                fuse_data_i,
  output logic [7:0]                     trim_o [tpr_pkg::FUSE_WORDS],
  output logic                           init_done_o,
  input  wire logic                      cc_attach_i,
  input  wire logic                      cc_orient_i,
  input  wire logic                      cc_src_role_i,
  input  wire logic                      debug_acc_det_i,
  input  wire logic                      sink_en_req_i,
  input  wire logic                      source_en_req_i,
  output logic [3:0]                     cc_term_o,
  output logic                           toggle_en_o,
  output logic                           dead_battery_o,
  output logic                           attached_o,
  output logic                           orient_o,
  output logic                           bmc_en_o,
  output logic                           detach_by_cc_o,
  output logic                           int_n_o,
  output logic                           int_n_oe_o,
  output logic                           debug_acc_out_n_o,
  output logic                           debug_acc_out_n_oe_o,
  output logic                           sink_switch_en_o,
  output logic                           source_switch_en_o
);
  import tpr_pkg::*;
  tpr_state_t         st_q, st_d;
  logic [IRQ_W-1:0]   irq_q, irq_d, irq_set;
  logic [6:0]         addr_q, addr_d;
  logic               srst_q, srst_d, orient_q, orient_d, gp_q, gp_d;
  logic               snk_q, snk_d, srcs_q, srcs_d, dbg_q, dbg_d, att_q, att_d;
  logic               vbus_deb_q, vbus_deb_d, att_prev_q;
  logic [3:0]         deb_q, deb_d;
  logic               fuse_start, fuse_done, full_rst;
  ////////////////////////////////////////////////////////////////
  // full reset is the system reset input alone; soft reset is applied in the register block and does not reset the fuse loader
  assign full_rst   = sys_rst_i; // [RULE1]
  assign fuse_start = (st_q == ST_OFF) && (vdd_good_i || vbus_good_i); // [RULE1]
  tpr_fuse_loader u_fuse
  (
    .mclk_i      (mclk_i),
    .sys_rst_i   (full_rst),
    .start_i     (fuse_start),
    .fuse_addr_o (fuse_addr_o),
    .fuse_data_i (fuse_data_i),
    .trim_o      (trim_o),
    .done_o      (fuse_done)
  );
  ////////////////////////////////////////////////////////////////
  function automatic logic [6:0] sel_addr(input logic pin, input logic swap);
    sel_addr = ADDR_BASE | {4'h0, swap, pin, 1'b0} >> 1;
  endfunction : sel_addr
  always_comb
  begin
    st_d   = st_q;
    srst_d = soft_reset_bit_i | srst_q;
    irq_set = '0;
    addr_d = addr_q;
    gp_d   = gp_q;
    unique case (st_q)
      ST_OFF:  if (fuse_start) st_d = ST_FUSE; // [RULE1]
      ST_FUSE:
        if (fuse_done)
        begin
          st_d   = ST_INIT;
          addr_d = sel_addr(addr_select_pin_i, serial_pair_swap_i); // [RULE8] [RULE9]
        end
      ST_INIT:
      begin
        irq_set[IRQ_PORT_PWR] = 1'b1; // [RULE16]
        irq_set[IRQ_INIT]     = 1'b1; // [RULE16]
        st_d = vdd_good_i ? ST_IDLE : ST_DEAD; // [RULE5]
        srst_d = 1'b0; // [RULE18]
      end
      ST_DEAD: if (vdd_good_i) st_d = ST_IDLE; // [RULE5] [RULE6]
      ST_IDLE:
        if (look_for_connection_cmd_i) st_d = ST_TOGG; // [RULE7]
      ST_TOGG:
        if (cc_attach_i) st_d = ST_ATT; // [RULE14]
      ST_ATT:
        if (cc_src_role_i ? !cc_attach_i : !vbus_deb_q) st_d = ST_IDLE; // [RULE14] [RULE15]
      default: st_d = ST_OFF;
    endcase
    if (!vdd_good_i && !vbus_good_i) st_d = ST_OFF;
    else if (!vdd_good_i && st_q inside {ST_IDLE, ST_TOGG, ST_ATT}) st_d = ST_DEAD; // [RULE5]
    if (st_q != ST_FUSE && st_q != ST_OFF) gp_d = gp_out_val_i; // [RULE8]
    if (st_q == ST_TOGG && st_d == ST_ATT) irq_set[IRQ_ATTACH] = 1'b1;
    if (st_q == ST_ATT && st_d != ST_ATT) irq_set[IRQ_DETACH] = 1'b1;
    if (debug_acc_det_i && !dbg_q) irq_set[IRQ_DEBUG] = 1'b1;
    irq_d = (irq_q & ~irq_clr_i) | irq_set; // [RULE17]
    orient_d = (st_q == ST_TOGG && cc_attach_i) ? cc_orient_i : orient_q; // [RULE14]
    att_d  = (st_d == ST_ATT);
    snk_d  = att_d && !cc_src_role_i && sink_en_req_i; // [RULE12]
    srcs_d = att_d && cc_src_role_i && source_en_req_i; // [RULE13]
    dbg_d  = debug_acc_det_i;
    if (vbus_good_i == vbus_deb_q) deb_d = '0;
    else deb_d = deb_q + 4'h1;
    vbus_deb_d = (deb_q == DEB_MAX) ? vbus_good_i : vbus_deb_q; // [RULE15]
  end
  always_ff @(posedge mclk_i)
  begin
    if (full_rst)
    begin
      st_q <= ST_OFF;
      irq_q <= '0;
      addr_q <= ADDR_BASE;
      srst_q <= 1'b0;
      orient_q <= 1'b0;
      gp_q <= 1'b0;
      snk_q <= 1'b0;
      srcs_q <= 1'b0;
      dbg_q <= 1'b0;
      att_q <= 1'b0;
      vbus_deb_q <= 1'b0;
      att_prev_q <= 1'b0;
      deb_q <= '0;
    end
    else if (srst_q && !(st_q inside {ST_OFF, ST_FUSE, ST_INIT}))
    begin
      // soft reset reruns fuse load and defaults
      // off excluded, else a pending reset would pin the machine in off
      st_q <= ST_OFF; // [RULE3]
      irq_q <= '0;
      addr_q <= ADDR_BASE;
      orient_q <= 1'b0;
      gp_q <= 1'b0;
      snk_q <= 1'b0;
      srcs_q <= 1'b0;
      att_q <= 1'b0;
      att_prev_q <= 1'b0;
      deb_q <= '0;
      vbus_deb_q <= 1'b0;
      dbg_q <= 1'b0;
      srst_q <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
      irq_q <= irq_d;
      addr_q <= addr_d;
      srst_q <= srst_d;
      orient_q <= orient_d;
      gp_q <= gp_d;
      snk_q <= snk_d;
      srcs_q <= srcs_d;
      dbg_q <= dbg_d;
      att_q <= att_d;
      vbus_deb_q <= vbus_deb_d;
      att_prev_q <= att_q;
      deb_q <= deb_d;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Rd everywhere except while in ST_TOGG, attached included
  assign cc_term_o = (st_q == ST_TOGG) ? ROLE_RP_RP : ROLE_RD_RD; // [RULE4] [RULE6]
  assign toggle_en_o = (st_q == ST_TOGG); // [RULE7]
  assign dead_battery_o = (st_q == ST_DEAD);
  assign attached_o = att_q;
  assign orient_o = orient_q;
  assign bmc_en_o = att_q; // [RULE14]
  assign detach_by_cc_o = att_q && cc_src_role_i; // [RULE14]
  assign irq_stat_o = irq_q;
  assign soft_reset_bit_o = srst_q; // [RULE18]
  assign slave_addr_o = addr_q;
  // pin driven only after address sampling, so straps are not fought
  assign addr_select_gp_out_o = gp_q;
  assign addr_select_gp_out_oe_o = (st_q != ST_OFF) && (st_q != ST_FUSE); // [RULE8]
  assign int_n_o = 1'b0;
  assign int_n_oe_o = |(irq_q & ~irq_mask_i); // [RULE10]
  assign debug_acc_out_n_o = 1'b0;
  assign debug_acc_out_n_oe_o = dbg_q; // [RULE11]
  assign sink_switch_en_o = snk_q; // [RULE12]
  assign source_switch_en_o = srcs_q; // [RULE13]
  assign init_done_o = (st_q != ST_OFF) && (st_q != ST_FUSE);
endmodule : tpr_core
`default_nettype wire

//--- tpr_pkg.sv
// Functional notes
// [RULE1] power-on sequence loads all register defaults
// [RULE2] fuse trims read during power-on sequence
// [RULE3] soft reset bit repeats full reset
// [RULE4] unpowered: Rd pull-downs on both CC
// [RULE5] VBUS without main supply is dead battery
// [RULE6] dead battery keeps Rd, no toggling
// [RULE7] toggling starts only on look-for-connection command
// [RULE8] address pin sampled at power-up, then output
// [RULE9] address also depends on serial pin pairing
// [RULE10] interrupt output active-low open-drain
// [RULE11] debug accessory output open-drain
// [RULE12] sink switch push-pull active high
// [RULE13] source switch push-pull active high
// [RULE14] CC: attach/orientation, then role-based use
// [RULE15] upstream role uses VBUS for attach/detach; code uses debounced VBUS for detach only, attach from cc_attach_i
// [RULE16] interrupt asserted after power-up and soft reset
// [RULE17] write 1 clears interrupt bit, 0 ignored
// [RULE18] soft reset bit self-clears after reset
package tpr_pkg;
  localparam int          FUSE_WORDS    = 8;
  localparam int          FUSE_AW       = 3;
  localparam logic [2:0]  FUSE_LAST     = 3'h7;
  localparam logic [7:0]  FUSE_RST      = 8'h00;
  localparam int          IRQ_W         = 8;
  localparam int          IRQ_PORT_PWR  = 0;
  localparam int          IRQ_INIT      = 1;
  localparam int          IRQ_ATTACH    = 2;
  localparam int          IRQ_DETACH    = 3;
  localparam int          IRQ_DEBUG     = 4;
  localparam logic [6:0]  ADDR_BASE     = 7'h50;
  localparam int          ADDR_PAIR_BIT = 1;
  localparam logic [3:0]  ROLE_RD_RD    = 4'hA;
  localparam logic [3:0]  ROLE_RP_RP    = 4'h5;
  localparam real         DEB_NS        = 100.0;
  localparam real         CLK_NS        = 10.0;
  localparam int          DEB_CYC       = int'(DEB_NS / CLK_NS);
  localparam logic [3:0]  DEB_MAX       = 4'(DEB_CYC - 1);
  typedef enum logic [2:0]
  {
    ST_OFF   = 3'b000,
    ST_FUSE  = 3'b001,
    ST_INIT  = 3'b011,
    ST_DEAD  = 3'b010,
    ST_IDLE  = 3'b110,
    ST_TOGG  = 3'b111,
    ST_ATT   = 3'b101
  } tpr_state_t;
endpackage : tpr_pkg

//--- tpr_fuse_loader.sv
`timescale 1ns/1ps
`default_nettype none
module tpr_fuse_loader
(
  input  wire logic                      mclk_i,
  input  wire logic                      sys_rst_i,
  input  wire logic                      start_i,
  output logic [tpr_pkg::FUSE_AW-1:0]    fuse_addr_o,
  input  wire logic [7:0]                fuse_data_i,
  output logic [7:0]                     trim_o [tpr_pkg::FUSE_WORDS],
  output logic                           done_o
);
  import tpr_pkg::*;
  logic [FUSE_AW-1:0] ptr_q, ptr_d;
  logic               busy_q, busy_d, done_q, done_d;
  logic [7:0]         trim_q [FUSE_WORDS];
  logic [7:0]         trim_d [FUSE_WORDS];
  ////////////////////////////////////////////////////////////////
  always_comb
  begin
    ptr_d  = ptr_q;
    busy_d = busy_q;
    done_d = 1'b0;
    trim_d = trim_q;
    if (start_i)
    begin
      ptr_d  = '0;
      busy_d = 1'b1;
      for (int i = 0; i < FUSE_WORDS; i++) trim_d[i] = FUSE_RST;
    end
    else if (busy_q)
    begin
      trim_d[ptr_q] = fuse_data_i; // [RULE2]
      ptr_d = ptr_q + 1'b1;
      if (ptr_q == FUSE_LAST)
      begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
    end
  end
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      ptr_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      for (int i = 0; i < FUSE_WORDS; i++) trim_q[i] <= FUSE_RST;
    end
    else
    begin
      ptr_q  <= ptr_d;
      busy_q <= busy_d;
      done_q <= done_d;
      trim_q <= trim_d;
    end
  end
  assign fuse_addr_o = ptr_q;
  assign trim_o      = trim_q;
  assign done_o      = done_q;
endmodule : tpr_fuse_loader
`default_nettype wire

//--- tpr_fuse_rom.sv
`timescale 1ns/1ps
`default_nettype none
module tpr_fuse_rom
(
  input  wire logic [tpr_pkg::FUSE_AW-1:0] addr_i,
  output logic      [7:0]                  data_o
);
  // distinct word per address so a skipped or doubled read shows up
  assign data_o = {5'h15, addr_i};
endmodule : tpr_fuse_rom
`default_nettype wire

//--- tpr_core_props.sv
`timescale 1ns/1ps
`default_nettype none
module tpr_core_props
(
  input wire logic                      mclk_i,
  input wire logic                      sys_rst_i,
  input wire logic                      vdd_good_i,
  input wire logic                      vbus_good_i,
  input wire logic                      look_for_connection_cmd_i,
  input wire logic                      soft_reset_bit_i,
  input wire logic                      soft_reset_bit_o,
  input wire logic [tpr_pkg::IRQ_W-1:0] irq_clr_i,
  input wire logic [tpr_pkg::IRQ_W-1:0] irq_mask_i,
  input wire logic [tpr_pkg::IRQ_W-1:0] irq_stat_o,
  input wire logic [3:0]                cc_term_o,
  input wire logic                      toggle_en_o,
  input wire logic                      dead_battery_o,
  input wire logic                      int_n_o,
  input wire logic                      int_n_oe_o,
  input wire logic                      debug_acc_out_n_o
);
  import tpr_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  property p_int_low; int_n_o == 1'b0; endproperty
  a_int_low: assert property (p_int_low) else $error("int level not low");
  property p_int_oe; $stable(irq_stat_o & ~irq_mask_i) |-> int_n_oe_o == |(irq_stat_o & ~irq_mask_i); endproperty
  a_int_oe: assert property (p_int_oe) else $error("int enable wrong");
  property p_dbg_low; debug_acc_out_n_o == 1'b0; endproperty
  a_dbg_low: assert property (p_dbg_low) else $error("debug level not low");
  property p_dead_rd; dead_battery_o |-> cc_term_o == ROLE_RD_RD && !toggle_en_o; endproperty
  a_dead_rd: assert property (p_dead_rd) else $error("dead battery not Rd");
  property p_off_rd; (!vdd_good_i && !vbus_good_i) [*2] |-> cc_term_o == ROLE_RD_RD; endproperty
  a_off_rd: assert property (p_off_rd) else $error("unpowered not Rd");
  // toggling may only follow a command seen one or two edges earlier
  property p_no_tog; $rose(toggle_en_o) |-> $past(look_for_connection_cmd_i) || $past(look_for_connection_cmd_i, 2); endproperty
  a_no_tog: assert property (p_no_tog) else $error("toggle without command");
  property p_srst; $fell(soft_reset_bit_o) |-> ##[0:1] (irq_stat_o[IRQ_PORT_PWR] && irq_stat_o[IRQ_INIT]); endproperty
  a_srst: assert property (p_srst) else $error("soft reset end without events");
  property p_keep; irq_stat_o[IRQ_INIT] && !irq_clr_i[IRQ_INIT] && !soft_reset_bit_i && !soft_reset_bit_o && vdd_good_i |=> irq_stat_o[IRQ_INIT]; endproperty
  a_keep: assert property (p_keep) else $error("event bit lost");
endmodule : tpr_core_props
bind tpr_core tpr_core_props u_props (.mclk_i, .sys_rst_i, .vdd_good_i, .vbus_good_i,
  .look_for_connection_cmd_i, .soft_reset_bit_i, .soft_reset_bit_o, .irq_clr_i, .irq_mask_i,
  .irq_stat_o, .cc_term_o, .toggle_en_o, .dead_battery_o, .int_n_o, .int_n_oe_o,
  .debug_acc_out_n_o);
`default_nettype wire

//--- tpr_core_test.sv
`timescale 1ns/1ps
`default_nettype none
module tpr_core_test;
  import tpr_pkg::*;
  logic mclk_i, sys_rst_i, vdd_good_i, vbus_good_i, soft_reset_bit_i, look_for_connection_cmd_i;
  logic addr_select_pin_i, serial_pair_swap_i, gp_out_val_i, cc_attach_i, cc_orient_i;
  logic cc_src_role_i, debug_acc_det_i, sink_en_req_i, source_en_req_i, soft_reset_bit_o;
  logic addr_select_gp_out_o, addr_select_gp_out_oe_o, init_done_o, toggle_en_o, dead_battery_o;
  logic attached_o, orient_o, bmc_en_o, detach_by_cc_o, int_n_o, int_n_oe_o, debug_acc_out_n_o;
  logic debug_acc_out_n_oe_o, sink_switch_en_o, source_switch_en_o;
  logic [7:0] irq_clr_i, irq_mask_i, irq_stat_o, fuse_data_i;
  logic [7:0] trim_o [FUSE_WORDS];
  logic [6:0] slave_addr_o;
  logic [2:0] fuse_addr_o;
  logic [3:0] cc_term_o;
  int         n_fail;
  int         n_tests;
  ////////////////////////////////////////////////////////////////////////////////
  tpr_core DUT (.mclk_i, .sys_rst_i, .vdd_good_i, .vbus_good_i, .soft_reset_bit_i,
    .soft_reset_bit_o, .look_for_connection_cmd_i, .irq_clr_i, .irq_mask_i, .irq_stat_o,
    .addr_select_pin_i, .serial_pair_swap_i, .slave_addr_o, .gp_out_val_i,
    .addr_select_gp_out_o, .addr_select_gp_out_oe_o, .fuse_addr_o, .fuse_data_i, .trim_o,
    .init_done_o, .cc_attach_i, .cc_orient_i, .cc_src_role_i, .debug_acc_det_i, .sink_en_req_i,
    .source_en_req_i, .cc_term_o, .toggle_en_o, .dead_battery_o, .attached_o, .orient_o,
    .bmc_en_o, .detach_by_cc_o, .int_n_o, .int_n_oe_o, .debug_acc_out_n_o,
    .debug_acc_out_n_oe_o, .sink_switch_en_o, .source_switch_en_o);
  tpr_fuse_rom u_rom (.addr_i(fuse_addr_o), .data_o(fuse_data_i));
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : tk
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // bounded wait for the init event, then sample mid-cycle
  task automatic wi();
    for (int i = 0; i < 300 && irq_stat_o[IRQ_INIT] !== 1'b1; i++) tk(1);
    @(negedge mclk_i);
  endtask : wi
  task automatic pwr(input logic p, input logic s, input logic d, input logic b);
    tk(1);
    sys_rst_i <= 1'b1;
    {addr_select_pin_i, serial_pair_swap_i, vdd_good_i, vbus_good_i} <= {p, s, d, b};
    tk(12);
    sys_rst_i <= 1'b0;
    wi();
  endtask : pwr
  task automatic pulse_cmd();
    tk(1);
    look_for_connection_cmd_i <= 1'b1;
    tk(1);
    look_for_connection_cmd_i <= 1'b0;
    tk(3);
    @(negedge mclk_i);
  endtask : pulse_cmd
  task automatic close_out();
    $display("checks %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    tk(5000);
    n_fail++;
    close_out();
  end
  initial
  begin
    sys_rst_i = 1'b1;
    {vdd_good_i, vbus_good_i, soft_reset_bit_i, look_for_connection_cmd_i} = '0;
    {addr_select_pin_i, serial_pair_swap_i, gp_out_val_i, cc_attach_i, cc_orient_i} = '0;
    {cc_src_role_i, debug_acc_det_i, sink_en_req_i, source_en_req_i} = '0;
    {irq_clr_i, irq_mask_i} = '0;
    pwr(1'b1, 1'b0, 1'b0, 1'b0);
    chk("cc_term", 8'(ROLE_RD_RD), 8'(cc_term_o));
    chk("irq_stat", 8'h00, irq_stat_o);
    chk("gp_oe", 8'h00, 8'(addr_select_gp_out_oe_o));
    tk(1);
    vbus_good_i <= 1'b1;
    wi();
    chk("dead", 8'h01, 8'(dead_battery_o));
    chk("irq_stat", 8'h03, irq_stat_o & 8'h03);
    chk("int_oe", 8'h01, 8'(int_n_oe_o));
    chk("addr", 8'h51, 8'(slave_addr_o));
    chk("gp_oe", 8'h01, 8'(addr_select_gp_out_oe_o));
    for (int i = 0; i < FUSE_WORDS; i++) chk("trim", {5'h15, 3'(i)}, trim_o[i]);
    pulse_cmd();
    chk("toggle", 8'h00, 8'(toggle_en_o));
    tk(1);
    vdd_good_i <= 1'b1;
    tk(5);
    @(negedge mclk_i);
    chk("dead", 8'h00, 8'(dead_battery_o));
    chk("toggle", 8'h00, 8'(toggle_en_o));
    pulse_cmd();
    chk("cc_term", 8'(ROLE_RP_RP), 8'(cc_term_o));
    tk(1);
    irq_clr_i <= 8'h01;
    tk(1);
    {irq_clr_i, irq_mask_i} <= {8'h00, 8'h02};
    tk(2);
    @(negedge mclk_i);
    chk("irq_stat", 8'h02, irq_stat_o & 8'h03);
    chk("int_oe", 8'h00, 8'(int_n_oe_o));
    tk(1);
    {irq_mask_i, cc_attach_i, sink_en_req_i, debug_acc_det_i} <= {8'h00, 3'b111};
    tk(30);
    @(negedge mclk_i);
    chk("attached", 8'h01, 8'(attached_o & bmc_en_o));
    chk("sink_sw", 8'h01, 8'(sink_switch_en_o));
    chk("src_sw", 8'h00, 8'(source_switch_en_o));
    chk("debug_oe", 8'h01, 8'(debug_acc_out_n_oe_o));
    tk(1);
    vbus_good_i <= 1'b0;
    tk(30);
    @(negedge mclk_i);
    chk("attached", 8'h00, 8'(attached_o));
    tk(1);
    soft_reset_bit_i <= 1'b1;
    tk(1);
    soft_reset_bit_i <= 1'b0;
    @(negedge mclk_i);
    chk("soft_bit", 8'h01, 8'(soft_reset_bit_o));
    for (int i = 0; i < 300 && soft_reset_bit_o !== 1'b0; i++) @(negedge mclk_i);
    chk("soft_bit", 8'h00, 8'(soft_reset_bit_o));
    chk("irq_stat", 8'h03, irq_stat_o & 8'h0F);
    chk("toggle", 8'h00, 8'(toggle_en_o));
    for (int k = 0; k < 4; k++)
    begin
      pwr(k[0], k[1], 1'b1, 1'b0);
      chk("addr", 8'(ADDR_BASE | 7'(k)), 8'(slave_addr_o));
    end
    close_out();
  end
endmodule : tpr_core_test
`default_nettype wire
